/* File: shared/esc_consts.vh */
// Constants for the engine start and cutoff sequencer.
`ifndef ESC_CONSTS_VH
`define ESC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ESC_OFS_CMD        8'h00
`define ESC_OFS_STATUS     8'h04
`define ESC_OFS_IRQ_STAT   8'h08
`define ESC_OFS_IRQ_MASK   8'h0C

// ----------------------------------------------------------------------
// Command register bit positions (write one to issue)
// ----------------------------------------------------------------------
`define ESC_CMD_BYPASS     0
`define ESC_CMD_START      1
`define ESC_CMD_CUTOFF     2

// ----------------------------------------------------------------------
// Interrupt status and mask bit positions
// ----------------------------------------------------------------------
`define ESC_EV_READY       0
`define ESC_EV_CUTOFF      1
`define ESC_EV_MAINSTAGE   2
`define ESC_EV_FAIL        3
`define ESC_EV_W           4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ESC_RST_MASK       4'h0

// ----------------------------------------------------------------------
// Default timer durations in pclk cycles
// ----------------------------------------------------------------------
`define ESC_T_DELAY        16'h0040
`define ESC_T_IGN          16'h0080
`define ESC_T_SPARK        16'h0100
`define ESC_T_HELIUM       16'h0040

`endif

/* File: design/esc_sequencer.v */
// Engine start, mainstage transition and cutoff sequencer with APB slave.
`timescale 1ns/1ps
`include "esc_consts.vh"

module esc_sequencer #(
    parameter        CW       = 16,
    parameter [15:0] T_DELAY  = `ESC_T_DELAY,
    parameter [15:0] T_IGN    = `ESC_T_IGN,
    parameter [15:0] T_SPARK  = `ESC_T_SPARK,
    parameter [15:0] T_HELIUM = `ESC_T_HELIUM
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire        mainstage_enable,
    input  wire        ignition_detect,
    input  wire        start_tank_depressed,
    input  wire        thrust_ok_a,
    input  wire        thrust_ok_b,
    output reg         engine_ready,
    output reg         spark_igniter,
    output reg         spark_gas_generator,
    output reg         helium_ctl,
    output reg         ignition_phase_ctl,
    output reg         start_tank_discharge_ctl,
    output reg         mainstage_ctl,
    output reg         irq
);

    // ------------------------------------------------------------------
    // State encoding
    // ------------------------------------------------------------------
    // One bit per state, so status can show the state word as it is.
    // SHUT   after reset; the helium timer is already at zero.
    // READY  engine ready shown; start, bypass and cutoff taken.
    // DELAY  sparks, helium, ignition phase on; delay runs.
    // IGN    discharge open; the ignition phase timer runs.
    // SPARK  mainstage open; thrust must come before spark expiry.
    // MAIN   steady state; only a cutoff moves on.
    // CUT    helium on until its timer ends, then re-arm.
    // An illegal code falls back to SHUT, which re-arms alike.
    localparam [6:0] ST_SHUT  = 7'h01;
    localparam [6:0] ST_READY = 7'h02;
    localparam [6:0] ST_DELAY = 7'h04;
    localparam [6:0] ST_IGN   = 7'h08;
    localparam [6:0] ST_SPARK = 7'h10;
    localparam [6:0] ST_MAIN  = 7'h20;
    localparam [6:0] ST_CUT   = 7'h40;

    // The phase timer serves delay, ignition and helium in turn, as
    // they never overlap; the spark timer runs on into mainstage and
    // so needs a counter of its own.
    reg  [6:0]          state;
    reg  [CW-1:0]       seq_cnt;
    reg  [CW-1:0]       spark_cnt;
    reg                 spark_run;
    // One-cycle command pulses from a write to the command word.
    reg                 cmd_bypass;
    reg                 cmd_start;
    reg                 cmd_cutoff;
    // Sticky events, their mask and the per-cycle event pulses.
    reg  [`ESC_EV_W-1:0] irq_stat;
    reg  [`ESC_EV_W-1:0] irq_mask;
    reg  [`ESC_EV_W-1:0] ev;

    wire                access;
    wire                wr_done;
    wire                rd_req;
    wire                cut_req;
    wire                thrust_any;
    wire                mapped;
    wire                spark_expiring;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------
    // One wait state: pready rises on the second access cycle, and a
    // write lands only on the edge that samples pready high.
    // Register map, one word each:
    //   command   write only; bit 0 bypass, 1 start, 2 cutoff.
    //   status    read only; state, control outputs and inputs.
    //   irq stat  write one to clear.
    //   irq mask  read and write; a set bit lets its event out.
    // Other offsets answer pslverr, read zero and drop writes.
    assign access  = psel & penable;
    assign wr_done = access & pready & pwrite;
    assign rd_req  = access & ~pready & ~pwrite;
    assign mapped  = (paddr == `ESC_OFS_CMD) ||
                     (paddr == `ESC_OFS_STATUS) ||
                     (paddr == `ESC_OFS_IRQ_STAT) ||
                     (paddr == `ESC_OFS_IRQ_MASK);

    // Bypass and cutoff share one path so both behave identically.
    assign cut_req    = cmd_bypass | cmd_cutoff;
    assign thrust_any = thrust_ok_a | thrust_ok_b;

    // Last cycle of the spark timer; thrust seen only after it is
    // too late and leads to cutoff.
    assign spark_expiring = spark_run & (spark_cnt == {CW{1'b0}});

    // Ready strobe, error flag and read data, all registered.
    // pslverr rises with pready, so an error never stands alone.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= access & ~pready;
            pslverr <= access & ~pready & ~mapped;
            prdata  <= 32'h0000_0000;
            // Read data is formed in the first access cycle so that
            // it stands with pready in the second.
            if (rd_req) begin
                case (paddr)
                    `ESC_OFS_STATUS: begin
                        // Inputs at 20:16, outputs and ready at 14:8,
                        // state at 6:0; the rest read as zero.
                        prdata <= {11'h000, thrust_ok_b, thrust_ok_a,
                                   start_tank_depressed, ignition_detect,
                                   mainstage_enable, 1'b0,
                                   mainstage_ctl, start_tank_discharge_ctl,
                                   ignition_phase_ctl, helium_ctl,
                                   spark_gas_generator, spark_igniter,
                                   engine_ready, 1'b0, state};
                    end
                    `ESC_OFS_IRQ_STAT: begin
                        prdata <= {28'h000_0000, irq_stat};
                    end
                    `ESC_OFS_IRQ_MASK: begin
                        prdata <= {28'h000_0000, irq_mask};
                    end
                    default: begin
                        prdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Command strobes
    // ------------------------------------------------------------------
    // Each command is a one-cycle pulse taken from a write of one.
    // Several ones at once are allowed; cutoff or bypass then wins
    // over start inside the sequencer.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_bypass <= 1'b0;
            cmd_start  <= 1'b0;
            cmd_cutoff <= 1'b0;
        end else begin
            cmd_bypass <= 1'b0;
            cmd_start  <= 1'b0;
            cmd_cutoff <= 1'b0;
            if (wr_done && paddr == `ESC_OFS_CMD) begin
                cmd_bypass <= pwdata[`ESC_CMD_BYPASS];
                cmd_start  <= pwdata[`ESC_CMD_START];
                cmd_cutoff <= pwdata[`ESC_CMD_CUTOFF];
            end
        end
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Every cutoff path is tested first in each state so that a cutoff
    // always wins over a start transition in the same cycle.
    // Timing in pclk edges from the edge that enters a phase:
    //   DELAY lasts T_DELAY edges, then waits for mainstage enable.
    //   IGN lasts T_IGN edges, then checks ignition and the tank.
    //   Sparks end T_SPARK edges after mainstage opens.
    //   Helium closes T_HELIUM edges after the cutoff edge, and
    //   the engine re-arms one edge later with both switches low.
    // A duration of zero wraps the counter into a very long phase,
    // so every duration must be at least one.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // Every control output is de-energized during reset.
            state                    <= ST_SHUT;
            seq_cnt                  <= {CW{1'b0}};
            spark_cnt                <= {CW{1'b0}};
            spark_run                <= 1'b0;
            engine_ready             <= 1'b0;
            spark_igniter            <= 1'b0;
            spark_gas_generator      <= 1'b0;
            helium_ctl               <= 1'b0;
            ignition_phase_ctl       <= 1'b0;
            start_tank_discharge_ctl <= 1'b0;
            mainstage_ctl            <= 1'b0;
            ev                       <= {`ESC_EV_W{1'b0}};
        end else begin
            ev <= {`ESC_EV_W{1'b0}};
            // Spark timer runs alongside the state machine and keeps
            // counting into mainstage, where the sparks are still on.
            if (spark_run) begin
                if (spark_expiring) begin
                    spark_run           <= 1'b0;
                    spark_igniter       <= 1'b0;
                    spark_gas_generator <= 1'b0;
                end else begin
                    spark_cnt <= spark_cnt - 1'b1;
                end
            end
            case (state)
                ST_SHUT, ST_CUT: begin
                    if (seq_cnt != {CW{1'b0}}) begin
                        seq_cnt <= seq_cnt - 1'b1;
                    end else begin
                        helium_ctl <= 1'b0;
                        // Reset conditions: helium vented, no thrust and
                        // no fresh cutoff pending.
                        if (!helium_ctl && !thrust_any && !cut_req) begin
                            state        <= ST_READY;
                            engine_ready <= 1'b1;
                            ev[`ESC_EV_READY] <= 1'b1;
                        end
                    end
                end
                ST_READY: begin
                    // Cutoff and bypass are tested before start.
                    if (cut_req) begin
                        state        <= ST_CUT;
                        engine_ready <= 1'b0;
                        seq_cnt      <= T_HELIUM[CW-1:0] - 1'b1;
                        ev[`ESC_EV_CUTOFF] <= 1'b1;
                    end else if (cmd_start) begin
                        state               <= ST_DELAY;
                        engine_ready        <= 1'b0;
                        spark_igniter       <= 1'b1;
                        spark_gas_generator <= 1'b1;
                        helium_ctl          <= 1'b1;
                        ignition_phase_ctl  <= 1'b1;
                        seq_cnt <= T_DELAY[CW-1:0] - 1'b1;
                    end
                end
                ST_DELAY, ST_IGN, ST_SPARK, ST_MAIN: begin
                    if (cut_req ||
                        (state == ST_IGN && seq_cnt == {CW{1'b0}} &&
                         (!ignition_detect || start_tank_depressed)) ||
                        (state == ST_SPARK && !thrust_any &&
                         (spark_expiring || !spark_run)) ||
                        (state == ST_MAIN && !thrust_any)) begin
                        // Sparks and discharge close too, so no igniter
                        // energy is left on with the valves shut.
                        state                    <= ST_CUT;
                        mainstage_ctl            <= 1'b0;
                        ignition_phase_ctl       <= 1'b0;
                        start_tank_discharge_ctl <= 1'b0;
                        spark_igniter            <= 1'b0;
                        spark_gas_generator      <= 1'b0;
                        spark_run                <= 1'b0;
                        seq_cnt <= T_HELIUM[CW-1:0] - 1'b1;
                        ev[`ESC_EV_CUTOFF] <= 1'b1;
                        ev[`ESC_EV_FAIL]   <= ~cut_req;
                    end else if (state == ST_DELAY) begin
                        // Without mainstage enable the phase holds;
                        // only a cutoff or bypass command ends it then.
                        if (seq_cnt != {CW{1'b0}}) begin
                            seq_cnt <= seq_cnt - 1'b1;
                        end else if (mainstage_enable) begin
                            state                    <= ST_IGN;
                            start_tank_discharge_ctl <= 1'b1;
                            seq_cnt <= T_IGN[CW-1:0] - 1'b1;
                        end
                    end else if (state == ST_IGN) begin
                        // Bad start conditions at expiry are caught by
                        // the cutoff test above, before this branch.
                        if (seq_cnt != {CW{1'b0}}) begin
                            seq_cnt <= seq_cnt - 1'b1;
                        end else begin
                            state                    <= ST_SPARK;
                            mainstage_ctl            <= 1'b1;
                            start_tank_discharge_ctl <= 1'b0;
                            spark_run                <= 1'b1;
                            spark_cnt <= T_SPARK[CW-1:0] - 1'b1;
                        end
                    end else if (state == ST_SPARK && thrust_any) begin
                        // Either switch alone is enough.
                        state <= ST_MAIN;
                        ev[`ESC_EV_MAINSTAGE] <= 1'b1;
                    end
                    // In mainstage nothing else changes.
                end
                default: begin
                    // An upset state code re-arms through SHUT.
                    state <= ST_SHUT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    // A new event in the clearing cycle survives the write of one.
    // Events: ready entered, cutoff entered, mainstage reached, and
    // a cutoff raised by a sensor condition rather than a command.
    // irq is registered, so it trails its status bit by one cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= {`ESC_EV_W{1'b0}};
            irq_mask <= `ESC_RST_MASK;
            irq      <= 1'b0;
        end else begin
            if (wr_done && paddr == `ESC_OFS_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[`ESC_EV_W-1:0]) | ev;
            end else begin
                irq_stat <= irq_stat | ev;
            end
            if (wr_done && paddr == `ESC_OFS_IRQ_MASK) begin
                irq_mask <= pwdata[`ESC_EV_W-1:0];
            end
            // Masking a pending bit drops irq but keeps the bit.
            irq <= |(irq_stat & irq_mask);
        end
    end

endmodule // esc_sequencer

/* File: tb/esc_seq_assertions.sv */
// Concurrent checks on the sequencer's control outputs.
`timescale 1ns/1ps
module esc_seq_assertions (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire mainstage_enable,
    input wire ignition_detect,
    input wire start_tank_depressed,
    input wire thrust_ok_a,
    input wire thrust_ok_b,
    input wire engine_ready,
    input wire spark_igniter,
    input wire spark_gas_generator,
    input wire helium_ctl,
    input wire ignition_phase_ctl,
    input wire start_tank_discharge_ctl,
    input wire mainstage_ctl
);
    // ------------------------------------------------------------------
    // Sequencing checks
    // ------------------------------------------------------------------
    // Everything runs on pclk; reset silences all checks.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    start_group_a: assert property ($rose(ignition_phase_ctl) |->
        spark_igniter && spark_gas_generator && helium_ctl && !engine_ready)
        else $error("start outputs not energized together");
    discharge_gate_a: assert property ($rose(start_tank_discharge_ctl) |->
        $past(mainstage_enable) && ignition_phase_ctl)
        else $error("discharge opened without stage enable");
    ign_gate_a: assert property ($rose(mainstage_ctl) |->
        $past(ignition_detect) && !$past(start_tank_depressed))
        else $error("mainstage without good start conditions");
    main_swap_a: assert property ($rose(mainstage_ctl) |->
        !start_tank_discharge_ctl && $past(start_tank_discharge_ctl))
        else $error("discharge not closed with mainstage");
    spark_pair_a: assert property ($fell(spark_igniter) |->
        !spark_gas_generator)
        else $error("spark exciters not off together");
    both_lost_a: assert property (mainstage_ctl && !spark_igniter
        && !thrust_ok_a && !thrust_ok_b |=> !mainstage_ctl)
        else $error("no cutoff after both switches lost");
    one_lost_a: assert property (mainstage_ctl && !spark_igniter
        && (thrust_ok_a ^ thrust_ok_b) && !psel && !$past(psel)
        |=> mainstage_ctl)
        else $error("cutoff on a single switch loss");
    main_steady_a: assert property (mainstage_ctl |->
        helium_ctl && ignition_phase_ctl && !engine_ready)
        else $error("steady outputs disturbed in mainstage");
    cutoff_group_a: assert property ($fell(ignition_phase_ctl) |->
        !mainstage_ctl && !start_tank_discharge_ctl)
        else $error("cutoff left a stage output energized");
    helium_late_a: assert property ($fell(ignition_phase_ctl) |->
        helium_ctl ##[1:300] !helium_ctl)
        else $error("helium not held then released after cutoff");
    rearm_cond_a: assert property ($rose(engine_ready) |->
        !helium_ctl && !$past(thrust_ok_a) && !$past(thrust_ok_b))
        else $error("ready raised before reset conditions held");
endmodule // esc_seq_assertions

bind esc_sequencer esc_seq_assertions u_esc_seq_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel),
    .mainstage_enable(mainstage_enable), .ignition_detect(ignition_detect),
    .start_tank_depressed(start_tank_depressed),
    .thrust_ok_a(thrust_ok_a), .thrust_ok_b(thrust_ok_b),
    .engine_ready(engine_ready), .spark_igniter(spark_igniter),
    .spark_gas_generator(spark_gas_generator), .helium_ctl(helium_ctl),
    .ignition_phase_ctl(ignition_phase_ctl),
    .start_tank_discharge_ctl(start_tank_discharge_ctl),
    .mainstage_ctl(mainstage_ctl));

/* File: tb/esc_engine_model.sv */
// Behavioural model of the stage sensors that answer the sequencer.
`timescale 1ns/1ps
module esc_engine_model (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       ignition_phase_ctl,
    input  wire       mainstage_ctl,
    input  wire       ign_good,
    input  wire       tank_low,
    input  wire       thr_a_en,
    input  wire       thr_b_en,
    output reg        mainstage_enable,
    output reg        ignition_detect,
    output reg        start_tank_depressed,
    output reg        thrust_ok_a,
    output reg        thrust_ok_b
);
    // ------------------------------------------------------------------
    // Sensor responses
    // ------------------------------------------------------------------
    reg [1:0] spin;

    // Thrust builds a few cycles after mainstage, and drops with it, so
    // the switches are low again before the sequencer can re-arm.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {mainstage_enable, ignition_detect} <= 2'h0;
            {start_tank_depressed, thrust_ok_a, thrust_ok_b} <= 3'h0;
            spin <= 2'h0;
        end else begin
            mainstage_enable <= ignition_phase_ctl;
            ignition_detect <= ignition_phase_ctl & ign_good;
            start_tank_depressed <= tank_low;
            spin <= mainstage_ctl ? spin + {1'b0, spin != 2'h3} : 2'h0;
            thrust_ok_a <= (spin == 2'h3) & thr_a_en;
            thrust_ok_b <= (spin == 2'h3) & thr_b_en;
        end
    end
endmodule // esc_engine_model

/* File: tb/tb_esc_sequencer.sv */
// Self-checking testbench for the engine start and cutoff sequencer.
`timescale 1ns/1ps
module tb_esc_sequencer;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    reg         pwrite = 1'b0, ign_good = 1'b1, tank_low = 1'b0;
    reg         thr_a_en = 1'b1, thr_b_en = 1'b1;
    reg  [7:0]  paddr = 8'h00;
    reg  [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire        pready, pslverr, irq, engine_ready, spark_igniter;
    wire        spark_gas_generator, helium_ctl, ignition_phase_ctl;
    wire        start_tank_discharge_ctl, mainstage_ctl, mainstage_enable;
    wire        ignition_detect, start_tank_depressed;
    wire        thrust_ok_a, thrust_ok_b;
    wire [6:0]  outs = {mainstage_ctl, start_tank_discharge_ctl,
                        ignition_phase_ctl, helium_ctl, spark_gas_generator,
                        spark_igniter, engine_ready};
    int         bad_count = 0, checks_done = 0, waited = 0;
    logic [31:0] rd;
    logic       er;

    // Short timers keep each start attempt to a few dozen cycles.
    esc_sequencer #(.T_DELAY(16'h0004), .T_IGN(16'h0004),
        .T_SPARK(16'h0008), .T_HELIUM(16'h0004)) u_esc_sequencer (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .mainstage_enable, .ignition_detect,
        .start_tank_depressed, .thrust_ok_a, .thrust_ok_b, .engine_ready,
        .spark_igniter, .spark_gas_generator, .helium_ctl,
        .ignition_phase_ctl, .start_tank_discharge_ctl, .mainstage_ctl,
        .irq);
    esc_engine_model u_esc_engine_model (.pclk, .presetn,
        .ignition_phase_ctl, .mainstage_ctl, .ign_good, .tank_low,
        .thr_a_en, .thr_b_en, .mainstage_enable, .ignition_detect,
        .start_tank_depressed, .thrust_ok_a, .thrust_ok_b);

    always #20 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask

    // One APB transfer; the request is held until pready is seen high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_bit(input int i, input logic v);
        int n;
        n = 0;
        while (outs[i] !== v && n < 300) begin
            @(posedge pclk);
            n++;
        end
        waited = n;
        chk(outs[i], v, "output never moved");
    endtask

    task start_seq;
        apb(1'b1, 8'h00, 32'h1);
        wait_bit(0, 1'b0);
        wait_bit(0, 1'b1);
        apb(1'b1, 8'h00, 32'h2);
        wait_bit(4, 1'b1);
        chk(outs, 7'h1E, "start outputs");
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task nominal;
        start_seq();
        wait_bit(5, 1'b1);
        chk(waited, 4, "delay phase length");
        chk(outs, 7'h3E, "discharge open");
        wait_bit(6, 1'b1);
        chk(waited, 4, "ignition phase length");
        chk(outs, 7'h5E, "mainstage entered");
        wait_bit(1, 1'b0);
        chk(waited, 8, "spark timer length");
        chk(outs, 7'h58, "sparks off");
        thr_b_en <= 1'b0;
        repeat (8) @(posedge pclk);
        chk(outs, 7'h58, "one switch lost");
        thr_a_en <= 1'b0;
        wait_bit(6, 1'b0);
        chk(outs, 7'h08, "both switches lost");
        wait_bit(3, 1'b0);
        chk(waited, 4, "helium timer length");
        wait_bit(0, 1'b1);
    endtask

    // Both switches silent, then only switch b answering.
    task thrust_cases;
        start_seq();
        wait_bit(6, 1'b1);
        wait_bit(6, 1'b0);
        chk(outs, 7'h08, "no thrust cutoff");
        wait_bit(0, 1'b1);
        thr_b_en <= 1'b1;
        start_seq();
        wait_bit(1, 1'b0);
        chk(outs, 7'h58, "one switch suffices");
        apb(1'b1, 8'h00, 32'h4);
        wait_bit(6, 1'b0);
        chk(outs, 7'h08, "cutoff command");
        wait_bit(3, 1'b0);
        wait_bit(0, 1'b1);
        thr_a_en <= 1'b1;
    endtask

    // Missing ignition, then a depressurized tank; each raises the irq.
    task fail_starts;
        for (int i = 0; i < 2; i++) begin
            apb(1'b1, 8'h0C, 32'h8);
            ign_good <= (i != 0);
            tank_low <= (i == 1);
            start_seq();
            wait_bit(4, 1'b0);
            chk(outs, 7'h08, "cutoff at ignition expiry");
            repeat (2) @(posedge pclk);
            chk(irq, 1'b1, "failure interrupt");
            apb(1'b1, 8'h0C, 32'h0);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0, "interrupt masked");
            apb(1'b1, 8'h08, 32'h8);
            apb(1'b1, 8'h0C, 32'h8);
            repeat (2) @(posedge pclk);
            chk(irq, 1'b0, "interrupt cleared");
            wait_bit(0, 1'b1);
            {ign_good, tank_low} <= 2'h2;
        end
    endtask

    task complete_run;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        wait_bit(0, 1'b1);
        chk(outs, 7'h01, "ready after reset");
        apb(1'b0, 8'h04, 32'h0);
        chk(rd[8:0], 9'h102, "status ready");
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped read");
        nominal();
        thr_a_en <= 1'b0;
        thr_b_en <= 1'b0;
        thrust_cases();
        fail_starts();
        complete_run();
    end

    // Watchdog against a hung wait.
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        complete_run();
    end
endmodule // tb_esc_sequencer
